// ===== spims_pkg.sv
// Constants, register map and field layouts of the serial peripheral port
// Notes on behaviour
// - Slave with select low is active; MISO driven only if its direction says output
// - Slave with select high: all pins inputs, no data accepted
// - Select rising in slave role resets bit counter and drops partial byte
// - Master with select as output: select pin has no effect on the port
// - Master with select as input: low level demotes to slave, sets done flag
// - Polarity and phase pick modes 0 to 3 with their sample and setup edges
// - Polarity bit 3 sets SCK idle level and which edge leads
// - Phase bit 2: zero samples on leading edge, one on trailing edge
// - Data driven on one SCK edge and captured on the opposite edge
// - Interrupt enable bit 7 requests interrupt while done flag and global enable set
// - Port enable bit 6 must be one for any transfer
// - Bit order bit 5: one sends LSB first, zero sends MSB first
// - Master select bit 4 picks role; after demotion software must set it again
// - Master rate codes give fosc divided by 4, 16, 64 or 128
// - Double speed status bit 0 halves the master divisor
// - Rate and double speed bits do nothing in slave role
// - Done flag bit 7 set on byte completion and on master mode fault
// - Done flag clears on vector taken, or status read then data access
// - Collision flag bit 6 set on data write during transfer; cleared only by status read then data access
// - Status bits 5 to 1 always read zero
// - Data write starts transmission; data read returns receive buffer
// - Master shifts eight bits, then stops SCK and sets done flag
// - Transmit single buffered, receive double buffered, overrun overwrites
// - Slave with select high keeps MISO off; preload allowed, no shifting
package spims_pkg;

    // Register addresses on the plain register port
    localparam logic [1:0] SPIMS_ADDR_CTRL = 2'h0;
    localparam logic [1:0] SPIMS_ADDR_STAT = 2'h1;
    localparam logic [1:0] SPIMS_ADDR_DATA = 2'h2;

    // Reset values
    localparam logic [7:0] SPIMS_CTRL_RST = 8'h00;
    localparam logic [7:0] SPIMS_DATA_RST = 8'h00;

    // Status field positions
    localparam int SPIMS_STAT_DONE = 7;
    localparam int SPIMS_STAT_COLL = 6;
    localparam int SPIMS_STAT_DBL = 0;

    // Master clock divisors, fosc over this figure
    localparam logic [7:0] SPIMS_DIV_0 = 8'h04;
    localparam logic [7:0] SPIMS_DIV_1 = 8'h10;
    localparam logic [7:0] SPIMS_DIV_2 = 8'h40;
    localparam logic [7:0] SPIMS_DIV_3 = 8'h80;

    // Frame geometry
    localparam logic [3:0] SPIMS_LAST_BIT = 4'h7;
    localparam logic [4:0] SPIMS_LAST_EDGE = 5'h0f;

    // Control register layout, bit 7 first
    typedef struct packed {
        logic irq_en;
        logic port_en;
        logic lsb_first;
        logic master;
        logic clock_idle_polarity;
        logic clock_sample_phase;
        logic [1:0] rate;
    } spims_ctrl_t;

endpackage : spims_pkg

// ===== spims_port.sv
// Serial peripheral port: master and slave shift engine with registers
//
// The register offsets and the address-and-strobe port are this design's own decisions.
module spims_port
    import spims_pkg::*;
(
    // Clock, reset, clock enable
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic en_i,
    // Register port
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Pin direction choices from the port logic, one means output
    input wire logic sck_dir_i,
    input wire logic mosi_dir_i,
    input wire logic miso_dir_i,
    input wire logic ss_dir_i,
    // Interrupt side
    input wire logic global_irq_en_i,
    input wire logic irq_ack_i,
    output logic irq_o,
    // Serial pins
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe_o,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_o,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_o,
    input wire logic ss_n_i
);

    // Shift one received bit in at the end opposite the send end
    function automatic logic [7:0] spims_shift(input logic [7:0] sh,
                                               input logic b,
                                               input logic lsb);
        spims_shift = lsb ? {b, sh[7:1]} : {sh[6:0], b};
    endfunction : spims_shift

    // Bit that goes out next
    function automatic logic spims_head(input logic [7:0] sh,
                                        input logic lsb);
        spims_head = lsb ? sh[0] : sh[7];
    endfunction : spims_head

    // Register state
    spims_ctrl_t ctrl_r;
    logic done_r;
    logic coll_r;
    logic dbl_r;
    logic arm_r;
    logic [7:0] rx_buf_r;
    logic [7:0] tx_hold_r;
    logic [7:0] rdata_r;
    logic irq_r;

    // Shift engine state
    logic [7:0] sh_r;
    logic out_r;
    logic m_busy_r;
    logic [6:0] div_cnt_r;
    logic [4:0] edge_cnt_r;
    logic sck_r;
    logic [3:0] bit_cnt_r;

    // Pin output registers
    logic sck_oe_r;
    logic mosi_oe_r;
    logic miso_oe_r;

    // Synchronisers; the first stage feeds only the second
    logic sck_m_r;
    logic sck_s_r;
    logic sck_d_r;
    logic ss_m_r;
    logic ss_s_r;
    logic ss_d_r;
    logic mosi_m_r;
    logic mosi_s_r;
    logic miso_m_r;
    logic miso_s_r;

    // Register port decode
    wire sel_ctrl = addr_i == SPIMS_ADDR_CTRL;
    wire sel_stat = addr_i == SPIMS_ADDR_STAT;
    wire sel_data = addr_i == SPIMS_ADDR_DATA;
    wire wr_ctrl = wr_i & sel_ctrl;
    wire wr_stat = wr_i & sel_stat;
    wire wr_data = wr_i & sel_data;
    wire rd_stat = rd_i & sel_stat;
    wire data_acc = (wr_i | rd_i) & sel_data;

    // Role and activity
    wire port_on = ctrl_r.port_en;
    wire is_master = port_on & ctrl_r.master;
    wire is_slave = port_on & ~ctrl_r.master;
    wire ss_low = ~ss_s_r;
    wire ss_rise = ss_s_r & ~ss_d_r;
    wire ss_fall = ~ss_s_r & ss_d_r;
    // Select pin only matters to a master when it is an input
    wire mode_fault = is_master & ~ss_dir_i & ss_low;
    wire slave_act = is_slave & ss_low;
    wire s_busy = slave_act & (bit_cnt_r != 4'h0);
    wire busy = m_busy_r | s_busy;

    // Master divider; slave ignores rate and double speed
    wire [7:0] div_sel = (ctrl_r.rate == 2'h0) ? SPIMS_DIV_0 :
                         (ctrl_r.rate == 2'h1) ? SPIMS_DIV_1 :
                         (ctrl_r.rate == 2'h2) ? SPIMS_DIV_2 :
                         SPIMS_DIV_3;
    // Half period in clocks; double speed halves the divisor
    wire [7:0] half_w = dbl_r ? (div_sel >> 2) : (div_sel >> 1);
    wire [6:0] half_lim = half_w[6:0] - 7'h01;
    wire m_tick = m_busy_r & (div_cnt_r == half_lim);
    // Even edge index is the leading edge
    wire m_lead = ~edge_cnt_r[0];
    wire m_samp = m_tick & (m_lead ^ ctrl_r.clock_sample_phase);
    wire m_setup = m_tick & ~(m_lead ^ ctrl_r.clock_sample_phase);
    wire m_done = m_tick & (edge_cnt_r == SPIMS_LAST_EDGE);

    // Slave edge detect on the synchronised clock
    wire s_edge = slave_act & (sck_s_r ^ sck_d_r);
    // Leading edge leaves the idle level
    wire s_lead = sck_s_r ^ ctrl_r.clock_idle_polarity;
    wire s_samp = s_edge & (s_lead ^ ctrl_r.clock_sample_phase);
    wire s_setup = s_edge & ~(s_lead ^ ctrl_r.clock_sample_phase);
    wire s_done = s_samp & (bit_cnt_r == SPIMS_LAST_BIT);

    // Shared datapath selection
    wire samp = m_samp | s_samp;
    wire setup = m_setup | s_setup;
    wire in_bit = is_master ? miso_s_r : mosi_s_r;
    wire [7:0] sh_nxt = samp ? spims_shift(sh_r, in_bit, ctrl_r.lsb_first)
                             : sh_r;
    wire xfer_done = m_done | s_done;
    // A write while busy only flags; the byte in flight is kept
    wire coll = wr_data & busy;
    wire load = wr_data & ~busy;
    wire m_start = load & is_master & ~mode_fault;

    // Flag set and clear terms; set wins over clear
    wire done_set = xfer_done | mode_fault;
    wire flag_clr = arm_r & data_acc;
    wire done_clr = flag_clr | irq_ack_i;
    wire done_nxt = done_set | (done_r & ~done_clr);
    wire coll_nxt = coll | (coll_r & ~flag_clr);

    // Read data mux; reserved status bits are zero
    wire [7:0] stat_val = {done_r, coll_r, 5'h00, dbl_r};
    wire [7:0] rd_val = sel_ctrl ? ctrl_r :
                        sel_stat ? stat_val :
                        sel_data ? rx_buf_r : 8'h00;

    // Pin enables; a disabled port leaves every pin to the port logic
    wire sck_oe_nxt = is_master & ~mode_fault & sck_dir_i;
    wire mosi_oe_nxt = is_master & ~mode_fault & mosi_dir_i;
    wire miso_oe_nxt = slave_act & miso_dir_i;

    // Input synchronisers
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sck_m_r <= 1'b0;
            sck_s_r <= 1'b0;
            sck_d_r <= 1'b0;
            ss_m_r <= 1'b1;
            ss_s_r <= 1'b1;
            ss_d_r <= 1'b1;
            mosi_m_r <= 1'b0;
            mosi_s_r <= 1'b0;
            miso_m_r <= 1'b0;
            miso_s_r <= 1'b0;
        end
        else if (en_i)
        begin
            sck_m_r <= sck_i;
            sck_s_r <= sck_m_r;
            sck_d_r <= sck_s_r;
            ss_m_r <= ss_n_i;
            ss_s_r <= ss_m_r;
            ss_d_r <= ss_s_r;
            mosi_m_r <= mosi_i;
            mosi_s_r <= mosi_m_r;
            miso_m_r <= miso_i;
            miso_s_r <= miso_m_r;
        end
    end

    // Control register; a mode fault drops master role
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            ctrl_r <= SPIMS_CTRL_RST;
        else if (en_i)
        begin
            if (wr_ctrl)
                ctrl_r <= wdata_i;
            if (mode_fault)
                ctrl_r.master <= 1'b0;
        end
    end

    // Status flags and the clear sequence arm
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            done_r <= 1'b0;
            coll_r <= 1'b0;
            dbl_r <= 1'b0;
            arm_r <= 1'b0;
        end
        else if (en_i)
        begin
            done_r <= done_nxt;
            coll_r <= coll_nxt;
            if (wr_stat)
                dbl_r <= wdata_i[SPIMS_STAT_DBL];
            // Status read with a flag up arms; the data access spends it
            if (rd_stat & (done_r | coll_r))
                arm_r <= 1'b1;
            else if (data_acc)
                arm_r <= 1'b0;
        end
    end

    // Read data stands one cycle after the strobe only
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rdata_r <= 8'h00;
        else if (en_i)
            rdata_r <= rd_i ? rd_val : 8'h00;
    end

    // Interrupt request, gated by global enable
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            irq_r <= 1'b0;
        else if (en_i)
            irq_r <= ctrl_r.irq_en & done_nxt & global_irq_en_i;
    end

    // Receive buffer: overwritten by each finished byte
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rx_buf_r <= SPIMS_DATA_RST;
        else if (en_i && xfer_done)
            rx_buf_r <= sh_nxt;
    end

    // Transmit byte kept for reload after an aborted slave frame
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            tx_hold_r <= SPIMS_DATA_RST;
        else if (en_i && load)
            tx_hold_r <= wdata_i;
    end

    // Shift register and output bit
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sh_r <= SPIMS_DATA_RST;
            out_r <= 1'b0;
        end
        else if (en_i)
        begin
            if (load)
            begin
                sh_r <= wdata_i;
                out_r <= spims_head(wdata_i, ctrl_r.lsb_first);
            end
            else if (is_slave & ss_rise)
            begin
                sh_r <= tx_hold_r;
                out_r <= spims_head(tx_hold_r, ctrl_r.lsb_first);
            end
            else
            begin
                sh_r <= sh_nxt;
                if (setup | (is_slave & ss_fall))
                    out_r <= spims_head(sh_r, ctrl_r.lsb_first);
            end
        end
    end

    // Slave bit counter; select high holds it at zero
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            bit_cnt_r <= 4'h0;
        else if (en_i)
        begin
            if (!slave_act)
                bit_cnt_r <= 4'h0;
            else if (s_done)
                bit_cnt_r <= 4'h0;
            else if (s_samp)
                bit_cnt_r <= bit_cnt_r + 4'h1;
        end
    end

    // Master clock generator; sixteen half periods per byte
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            m_busy_r <= 1'b0;
            div_cnt_r <= 7'h00;
            edge_cnt_r <= 5'h00;
        end
        else if (en_i)
        begin
            if (!is_master || mode_fault || m_done)
            begin
                m_busy_r <= 1'b0;
                div_cnt_r <= 7'h00;
                edge_cnt_r <= 5'h00;
            end
            else if (m_start)
                m_busy_r <= 1'b1;
            else if (m_tick)
            begin
                div_cnt_r <= 7'h00;
                edge_cnt_r <= edge_cnt_r + 5'h01;
            end
            else if (m_busy_r)
                div_cnt_r <= div_cnt_r + 7'h01;
        end
    end

    // SCK level; rests at the polarity level whenever not shifting
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            sck_r <= 1'b0;
        else if (en_i)
        begin
            if (!m_busy_r || mode_fault)
                sck_r <= ctrl_r.clock_idle_polarity;
            else if (m_tick)
                sck_r <= ~sck_r;
        end
    end

    // Pin enables registered so every output is a flip-flop
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sck_oe_r <= 1'b0;
            mosi_oe_r <= 1'b0;
            miso_oe_r <= 1'b0;
        end
        else if (en_i)
        begin
            sck_oe_r <= sck_oe_nxt;
            mosi_oe_r <= mosi_oe_nxt;
            miso_oe_r <= miso_oe_nxt;
        end
    end

    // Outputs
    assign rdata_o = rdata_r;
    assign irq_o = irq_r;
    assign sck_o = sck_r;
    assign sck_oe_o = sck_oe_r;
    assign mosi_o = out_r; // Same bit serves both roles
    assign mosi_oe_o = mosi_oe_r;
    assign miso_o = out_r;
    assign miso_oe_o = miso_oe_r;

endmodule : spims_port

// ===== spims_peer.sv
// Behavioural remote slave that answers the port in master role
module spims_peer (
    // Serial wires and select
    input wire logic sck_i,
    input wire logic sel_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    // Mode and data
    input wire logic clock_idle_polarity_i,
    input wire logic clock_sample_phase_i,
    input wire logic [7:0] tx_i,
    output logic [7:0] rx_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int n = 0;
    logic q = 1'b0;
    // Select presents first bit; release flips level, no stale data
    always @(sel_n_i)
    begin
        n = 0;
        q = sel_n_i ? ~q : tx_i[7];
    end
    // Sample edge shifts in, setup edge drives next bit
    always @(sck_i)
    begin
        if (!sel_n_i && (((sck_i != clock_idle_polarity_i) ^ clock_sample_phase_i) == 1'b1))
        begin
            rx_o = {rx_o[6:0], mosi_i};
            n++;
        end
        else if (!sel_n_i && n < 8)
            q = tx_i[7 - n];
    end
    assign miso_o = q;
endmodule : spims_peer

// ===== spims_port_checker.sv
// Port-level assertions for the serial peripheral port
module spims_port_checker
    import spims_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Register port
    input wire logic [1:0] addr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // Select and directions
    input wire logic miso_dir_i,
    input wire logic ss_dir_i,
    input wire logic ss_n_i,
    // Interrupt side
    input wire logic global_irq_en_i,
    input wire logic irq_ack_i,
    input wire logic irq_o,
    // Pin drivers
    input wire logic sck_oe_o,
    input wire logic mosi_oe_o,
    input wire logic miso_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // Long enough to pass the select synchronisers
    sequence s_ss_high; ss_n_i [*6]; endsequence
    sequence s_fault; (!ss_dir_i && !ss_n_i) [*6]; endsequence
    sequence s_stat_rd; rd_i && addr_i == SPIMS_ADDR_STAT; endsequence
    sequence s_data_rd; rd_i && addr_i == SPIMS_ADDR_DATA; endsequence
    sequence s_clear; (s_stat_rd and irq_o) ##[1:4] s_data_rd; endsequence

    a_miso_dir_ok: assert property (miso_oe_o |-> $past(miso_dir_i))
        else $error("miso driven while its direction is input");
    a_slave_quiet: assert property (miso_oe_o |-> !sck_oe_o && !mosi_oe_o)
        else $error("slave drives a master pin");
    a_ss_high_off: assert property (s_ss_high |-> !miso_oe_o)
        else $error("miso driven with select high");
    a_fault_drop: assert property (s_fault |-> !sck_oe_o && !mosi_oe_o)
        else $error("master pins still driven after mode fault");
    a_read_pulse: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside its cycle");
    a_stat_zero: assert property (s_stat_rd |=> rdata_o[5:1] == 5'h00)
        else $error("reserved status bits not zero");
    a_irq_gate: assert property (irq_o |-> $past(global_irq_en_i))
        else $error("interrupt without global enable");
    a_ack_clears: assert property (irq_ack_i |=> !irq_o)
        else $error("interrupt stays after vector taken");
    a_read_clears: assert property (s_clear |=> !irq_o)
        else $error("done flag not cleared by status then data");
endmodule : spims_port_checker

bind spims_port spims_port_checker u_chk (.clk_i, .rstn_i, .addr_i, .rd_i,
    .rdata_o, .miso_dir_i, .ss_dir_i, .ss_n_i, .global_irq_en_i, .irq_ack_i,
    .irq_o, .sck_oe_o, .mosi_oe_o, .miso_oe_o);

// ===== test_spi_master_slave_port.sv
// Self-checking bench for the serial peripheral port
module test_spi_master_slave_port;
    import spims_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rstn_i, en_i, wr_i, rd_i, irq_ack_i, global_irq_en_i;
    logic [1:0] addr_i;
    logic [7:0] wdata_i, rdata_o, ptx, prx, pcfg;
    logic sck_dir_i, mosi_dir_i, miso_dir_i, ss_dir_i, ss_n_i, irq_o;
    logic sck_i, sck_o, sck_oe_o, mosi_i, mosi_o, mosi_oe_o;
    logic miso_i, miso_o, miso_oe_o, pmiso, msck, mmosi, psel;
    int n_fail = 0;
    int comparisons = 0;

    // Wire levels from the port's enables; the bench and the peer drive otherwise
    assign sck_i = sck_oe_o ? sck_o : msck;
    assign mosi_i = mosi_oe_o ? mosi_o : mmosi;
    assign miso_i = miso_oe_o ? miso_o : pmiso;

    spims_port dut (.clk_i, .rstn_i, .en_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .sck_dir_i, .mosi_dir_i, .miso_dir_i, .ss_dir_i,
        .global_irq_en_i, .irq_ack_i, .irq_o, .sck_i, .sck_o, .sck_oe_o,
        .mosi_i, .mosi_o, .mosi_oe_o, .miso_i, .miso_o, .miso_oe_o, .ss_n_i);
    spims_peer u_peer (.sck_i(sck_i), .sel_n_i(psel), .mosi_i(mosi_i),
        .miso_o(pmiso), .clock_idle_polarity_i(pcfg[3]), .clock_sample_phase_i(pcfg[2]), .tx_i(ptx),
        .rx_o(prx));

    // 250 MHz system clock
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk

    task automatic wr(input int a, input logic [7:0] v);
        @(posedge clk_i);
        addr_i <= 2'(a);
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input int a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= 2'(a);
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd

    function automatic logic [7:0] rv(input logic [7:0] x, input logic l);
        rv = x;
        if (l)
            rv = {<<{x}};
    endfunction : rv

    task automatic tr();
        logic [7:0] d;
        for (int a = 0; a < 4; a++)
        begin
            rd(a, d);
            chk(d, 16'h0);
        end
        wr(1, 8'hff);
        wr(3, 8'h5a);
        rd(1, d);
        chk(d, 8'h01);
        rd(3, d);
        chk(d, 16'h0);
        $display("reset test done");
    endtask : tr

    // Master byte against the peer; rate, mode and order from i
    task automatic tm(input int i);
        logic [7:0] c, b, d;
        logic s, dl;
        int h, n, k;
        dl = i[2];
        c = {i[1], 1'b1, i[2] ^ i[1], 1'b1, i[1:0], i[1:0]};
        b = 8'h35 + 8'(i * 29);
        h = (i[1:0] == 3 ? 128 : 4 << (2 * i[1:0])) >> (1 + dl);
        global_irq_en_i <= i[0];
        ptx <= ~b;
        pcfg <= c;
        wr(1, {7'h00, dl});
        wr(0, c);
        psel <= 1'b0;
        wr(2, b);
        if (h > 8)
            wr(2, ~b);
        k = 0;
        n = 0;
        s = sck_o;
        while (k < 16 && n < 9000)
        begin
            @(posedge clk_i);
            #1 n++;
            if (sck_o !== s)
            begin
                k++;
                s = sck_o;
                if (k == 1)
                    n = 0;
            end
        end
        chk(16'(n), 16'(15 * h));
        chk(sck_o, c[3]);
        repeat (2) @(posedge clk_i);
        rd(1, d);
        chk(d, {1'b1, h > 8, 5'h00, dl});
        chk(irq_o, i[1] & i[0]);
        psel <= 1'b1;
        if (i == 3)
        begin
            @(posedge clk_i) irq_ack_i <= 1'b1;
            @(posedge clk_i) irq_ack_i <= 1'b0;
        end
        rd(2, d);
        if (h > 3)
            chk(d, rv(~b, c[5]));
        chk(prx, rv(b, c[5]));
        rd(1, d);
        chk(d, {7'h00, dl});
        $display("master case %0d done", i);
    endtask : tm

    // Remote master at fosc/16, half period of eight clocks
    task automatic sx(input int nb, input logic [7:0] v, input logic cp,
                      output logic [7:0] got);
        for (int i = 0; i < nb; i++)
        begin
            if (cp)
                msck <= ~msck;
            mmosi <= v[7 - i];
            repeat (8) @(posedge clk_i);
            msck <= ~msck;
            got[7 - i] = miso_o;
            repeat (8) @(posedge clk_i);
            if (!cp)
                msck <= ~msck;
        end
    endtask : sx

    task automatic ts(input logic [7:0] c, input logic [7:0] mb,
                      input logic [7:0] pre);
        logic [7:0] g;
        ss_n_i <= 1'b1;
        // Park the clock at idle long before select falls: no false edge
        msck <= c[3];
        wr(1, 8'h01);
        wr(0, c);
        wr(2, pre);
        miso_dir_i <= 1'b0;
        ss_n_i <= 1'b0;
        sx(3, ~mb, c[2], g);
        repeat (8) @(posedge clk_i);
        chk(miso_oe_o, 16'h0);
        ss_n_i <= 1'b1;
        miso_dir_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk(miso_oe_o, 16'h0);
        ss_n_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk(miso_oe_o, 16'h1);
        sx(8, rv(mb, c[5]), c[2], g);
        chk(rv(g, c[5]), pre);
        repeat (8) @(posedge clk_i);
        ss_n_i <= 1'b1;
        rd(1, g);
        chk(g, 8'h81);
        rd(2, g);
        chk(g, mb);
        rd(1, g);
        chk(g, 8'h01);
        $display("slave case %h done", c);
    endtask : ts

    task automatic tf();
        logic [7:0] d;
        wr(0, 8'h10);
        wr(2, 8'h77);
        repeat (40) @(posedge clk_i);
        chk(sck_o, 16'h0);
        // Double speed bit is still set from the slave cases
        rd(1, d);
        chk(d, 8'h01);
        ss_dir_i <= 1'b0;
        wr(0, 8'h50);
        ss_n_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        rd(0, d);
        chk(d, 8'h40);
        rd(1, d);
        chk(d, 8'h81);
        chk(sck_oe_o, 0);
        ss_n_i <= 1'b1;
        rd(2, d);
        ss_dir_i <= 1'b1;
        wr(0, 8'h50);
        rd(0, d);
        chk(d, 8'h50);
        $display("fault test done");
    endtask : tf

    task automatic results();
        $display("checks %0d failures %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    // Whole run needs about 15 us
    initial
    begin
        #100000 n_fail++;
        results();
    end

    initial
    begin
        {rstn_i, wr_i, rd_i, irq_ack_i, addr_i, wdata_i} = '0;
        {en_i, sck_dir_i, mosi_dir_i, miso_dir_i, ss_dir_i} = 5'h1f;
        {global_irq_en_i, msck, mmosi, ss_n_i, ptx, pcfg} = '0;
        psel = 1'b1;
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        tr();
        for (int i = 0; i < 8; i++)
            tm(i);
        for (int i = 0; i < 4; i++)
            ts({2'b01, i[0], 1'b0, i[1:0], 2'b11}, 8'h96 + 8'(i), 8'h3c ^ 8'(i));
        tf();
        results();
    end
endmodule : test_spi_master_slave_port
